// ---- actr_trim_regs.sv ----
// Channel 5 volume, gain and phase trim registers and channel 6 input configuration
`timescale 1ns/1ps

// Behaviour
// - Volume code zero raises ch5_mute_out; ch5_stream_out is not gated by it.
// - Code one is minus 100 dB, code two minus 99.5 dB.
// - Code 201 is unity gain, code 255 is plus 27 dB.
// - Volume register at 0x52, resets to 0xC9.
// - Gain trim bits 7-4: code zero minus 0.8 dB, 0.1 dB steps.
// - Gain trim field resets to eight, zero dB.
// - Gain trim low nibble is read-only zero; software writes only zero.
// - Gain trim register at 0x53, resets to 0x80.
// - Phase code delays channel by that many modulator ticks, up to 255.
// - Phase trim register at 0x54, resets to zero.
// - Channel 6 input config at 0x55, resets to 0x10.
// - Source code two selects pulse-density input, three clones channel one.
module actr_trim_regs (
    input  wire logic          core_clk_in,
    input  wire logic          reset_n_in,
    input  wire logic   [7:0]  reg_addr_in,
    input  wire logic          reg_write_in,
    input  wire logic   [7:0]  reg_wdata_in,
    output logic        [7:0]  reg_rdata_out,
    input  wire logic          mod_tick_in,
    input  wire logic          ch5_stream_in,
    output logic               ch5_stream_out,
    output logic        [7:0]  ch5_volume_code_out,
    output logic               ch5_mute_out,
    output logic signed [8:0]  ch5_volume_half_db_out,
    output logic        [3:0]  ch5_gain_trim_code_out,
    output logic signed [4:0]  ch5_gain_trim_tenth_db_out,
    output logic        [7:0]  ch5_phase_delay_code_out,
    output logic        [1:0]  ch6_input_source_sel_out,
    output logic               ch6_use_pulse_density_out,
    output logic               ch6_clone_ch1_out
);

    // ****************************************************************
    // Register storage and decode
    // ****************************************************************
    logic        [7:0] ch5_volume;
    logic        [3:0] ch5_gain_trim;
    logic        [7:0] ch5_phase_trim;
    logic        [7:0] ch6_input_config;

    logic              wr_volume;
    logic              wr_gain;
    logic              wr_phase;
    logic              wr_input;
    logic        [7:0] gain_reg_view;
    logic        [3:0] wdata_gain_field;
    logic        [7:0] next_rdata;
    logic        [1:0] src_sel;
    logic signed [8:0] next_half_db;
    logic signed [4:0] next_tenth_db;

    // Write strobes per register
    assign wr_volume = reg_write_in && (reg_addr_in == actr_pkg::ADDR_CH5_VOLUME);
    assign wr_gain   = reg_write_in && (reg_addr_in == actr_pkg::ADDR_CH5_GAIN_TRIM);
    assign wr_phase  = reg_write_in && (reg_addr_in == actr_pkg::ADDR_CH5_PHASE_TRIM);
    assign wr_input  = reg_write_in && (reg_addr_in == actr_pkg::ADDR_CH6_INPUT_CONFIG);

    assign gain_reg_view = {ch5_gain_trim, actr_pkg::GAIN_TRIM_LOW_NIBBLE};
    // Only the trim field of a write is kept; the low nibble has no storage
    assign wdata_gain_field = reg_wdata_in[actr_pkg::GAIN_TRIM_MSB:actr_pkg::GAIN_TRIM_LSB];

    // Read mux; unmapped addresses answer zero
    assign next_rdata =
        (reg_addr_in == actr_pkg::ADDR_CH5_VOLUME)       ? ch5_volume       :
        (reg_addr_in == actr_pkg::ADDR_CH5_GAIN_TRIM)    ? gain_reg_view    :
        (reg_addr_in == actr_pkg::ADDR_CH5_PHASE_TRIM)   ? ch5_phase_trim   :
        (reg_addr_in == actr_pkg::ADDR_CH6_INPUT_CONFIG) ? ch6_input_config :
        actr_pkg::READ_UNMAPPED;

    // ****************************************************************
    // Derived control codes
    // ****************************************************************
    // Half-dB offset from unity
    assign next_half_db  = $signed({1'b0, ch5_volume}) - $signed(actr_pkg::VOLUME_UNITY_CODE);
    // Tenth-dB trim offset from code eight
    assign next_tenth_db = $signed({1'b0, ch5_gain_trim}) - $signed(actr_pkg::GAIN_TRIM_ZERO);
    assign src_sel = ch6_input_config[actr_pkg::SRC_SEL_MSB:actr_pkg::SRC_SEL_LSB];

    // Register writes; reserved bits of the input config are kept as written
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            ch5_volume       <= actr_pkg::RST_CH5_VOLUME;
            ch5_gain_trim    <= actr_pkg::RST_CH5_GAIN_TRIM[7:4];
            ch5_phase_trim   <= actr_pkg::RST_CH5_PHASE_TRIM;
            ch6_input_config <= actr_pkg::RST_CH6_INPUT_CONFIG;
        end else begin
            if (wr_volume) begin
                ch5_volume <= reg_wdata_in;
            end
            // Only the upper nibble is stored
            if (wr_gain) begin
                ch5_gain_trim <= wdata_gain_field;
            end
            if (wr_phase) begin
                ch5_phase_trim <= reg_wdata_in;
            end
            if (wr_input) begin
                ch6_input_config <= reg_wdata_in;
            end
        end
    end

    // Registered outputs; each lags its register by one cycle so all leave a flop
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            reg_rdata_out              <= actr_pkg::READ_UNMAPPED;
            ch5_volume_code_out        <= actr_pkg::RST_CH5_VOLUME;
            ch5_mute_out               <= 1'b0;
            ch5_volume_half_db_out     <= 9'sh000;
            ch5_gain_trim_code_out     <= actr_pkg::RST_CH5_GAIN_TRIM[7:4];
            ch5_gain_trim_tenth_db_out <= 5'sh00;
            ch5_phase_delay_code_out   <= actr_pkg::RST_CH5_PHASE_TRIM;
            ch6_input_source_sel_out   <= 2'h0;
            ch6_use_pulse_density_out  <= 1'b0;
            ch6_clone_ch1_out          <= 1'b0;
        end else begin
            reg_rdata_out              <= next_rdata;
            ch5_volume_code_out        <= ch5_volume;
            ch5_mute_out               <= (ch5_volume == actr_pkg::VOLUME_MUTE_CODE);
            ch5_volume_half_db_out     <= next_half_db;
            ch5_gain_trim_code_out     <= ch5_gain_trim;
            ch5_gain_trim_tenth_db_out <= next_tenth_db;
            ch5_phase_delay_code_out   <= ch5_phase_trim;
            ch6_input_source_sel_out   <= src_sel;
            // Source decode; reserved codes select neither
            ch6_use_pulse_density_out  <= (src_sel == actr_pkg::SRC_PULSE_DENSITY);
            ch6_clone_ch1_out          <= (src_sel == actr_pkg::SRC_CLONE_CH1);
        end
    end

    // ****************************************************************
    // Phase trim delay line
    // ****************************************************************
    // Stream delayed by the phase code
    actr_delay_line u_delay (
        .core_clk_in   (core_clk_in),
        .reset_n_in    (reset_n_in),
        .mod_tick_in   (mod_tick_in),
        .stream_in     (ch5_stream_in),
        .delay_code_in (ch5_phase_trim),
        .stream_out    (ch5_stream_out)
    );

    // ****************************************************************
    // Checks
    // ****************************************************************
    // Mute on zero
    chk_mute_on_zero : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (ch5_volume == 8'h00) |=> ch5_mute_out)
        else $error("Volume code zero did not mute");
    chk_unmute_nonzero : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (ch5_volume != 8'h00) |=> !ch5_mute_out)
        else $error("Non-zero volume code muted the channel");
    chk_half_db_bottom : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (ch5_volume == 8'h01) |=> (ch5_volume_half_db_out == -9'sd200))
        else $error("Volume code one is not minus 100 dB");
    chk_half_db_second : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (ch5_volume == 8'h02) |=> (ch5_volume_half_db_out == -9'sd199))
        else $error("Volume code two is not minus 99.5 dB");
    chk_half_db_unity : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (ch5_volume == 8'hC9) |=> (ch5_volume_half_db_out == 9'sd0))
        else $error("Volume code 201 is not unity gain");
    chk_half_db_top : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (ch5_volume == 8'hFF) |=> (ch5_volume_half_db_out == 9'sd54))
        else $error("Volume code 255 is not plus 27 dB");
    chk_half_db_step : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wr_volume ##1 1'b1 |=> (ch5_volume_half_db_out
            == $signed({1'b0, $past(reg_wdata_in, 2)}) - 9'sd201))
        else $error("Volume gain not half-dB per code from 201");
    chk_volume_reset : assert property (
        @(posedge core_clk_in)
        !reset_n_in |=> (ch5_volume == 8'hC9 && ch5_phase_trim == 8'h00))
        else $error("Volume or phase register reset wrong");
    chk_trim_tenths : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        1'b1 |=> (ch5_gain_trim_tenth_db_out
            == $signed({1'b0, $past(ch5_gain_trim)}) - 5'sd8))
        else $error("Gain trim step wrong");
    chk_gain_reset : assert property (
        @(posedge core_clk_in)
        !reset_n_in |=> (gain_reg_view == 8'h80))
        else $error("Gain trim register reset wrong");
    chk_low_nibble : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (reg_addr_in == 8'h53) |=> (reg_rdata_out[3:0] == 4'h0))
        else $error("Gain trim low nibble read non-zero");
    chk_gain_readback : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        wr_gain ##1 (reg_addr_in == 8'h53 && !reg_write_in)
            |=> (reg_rdata_out[7:4] == $past(reg_wdata_in, 2) >> 4))
        else $error("Gain trim readback mismatch");
    chk_phase_copy : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        1'b1 |=> (ch5_phase_delay_code_out == $past(ch5_phase_trim)))
        else $error("Phase delay code output does not follow its register");
    chk_phase_reset : assert property (
        @(posedge core_clk_in)
        !reset_n_in |=> (ch5_phase_trim == 8'h00 && ch5_phase_delay_code_out == 8'h00))
        else $error("Phase trim reset wrong");
    chk_input_reset : assert property (
        @(posedge core_clk_in)
        !reset_n_in |=> (ch6_input_config == 8'h10))
        else $error("Channel 6 input config reset wrong");
    chk_source_decode : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (src_sel == 2'h2) |=> (ch6_use_pulse_density_out && !ch6_clone_ch1_out))
        else $error("Source code two not decoded as pulse-density");
    chk_clone_decode : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (src_sel == 2'h3) |=> (ch6_clone_ch1_out && !ch6_use_pulse_density_out))
        else $error("Source code three not decoded as channel one clone");
    chk_reserved_source : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !src_sel[1] |=> (!ch6_use_pulse_density_out && !ch6_clone_ch1_out))
        else $error("Reserved source code selected an input");

endmodule

// ---- actr_pkg.sv ----
// Package with register map, reset values, field positions and code constants for channel trims
package actr_pkg;

    // ****************************************************************
    // Register byte addresses
    // ****************************************************************
    localparam logic [7:0] ADDR_CH5_VOLUME        = 8'h52;
    localparam logic [7:0] ADDR_CH5_GAIN_TRIM     = 8'h53;
    localparam logic [7:0] ADDR_CH5_PHASE_TRIM    = 8'h54;
    localparam logic [7:0] ADDR_CH6_INPUT_CONFIG  = 8'h55;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] RST_CH5_VOLUME         = 8'hC9;
    localparam logic [7:0] RST_CH5_GAIN_TRIM      = 8'h80;
    localparam logic [7:0] RST_CH5_PHASE_TRIM     = 8'h00;
    localparam logic [7:0] RST_CH6_INPUT_CONFIG   = 8'h10;
    localparam logic [7:0] READ_UNMAPPED          = 8'h00;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int GAIN_TRIM_MSB  = 7;
    localparam int GAIN_TRIM_LSB  = 4;
    localparam int SRC_SEL_MSB    = 6;
    localparam int SRC_SEL_LSB    = 5;
    localparam logic [3:0] GAIN_TRIM_LOW_NIBBLE = 4'h0;

    // ****************************************************************
    // Code points
    // ****************************************************************
    localparam logic [7:0] VOLUME_MUTE_CODE   = 8'h00;
    localparam logic [8:0] VOLUME_UNITY_CODE  = 9'h0C9;
    localparam logic [4:0] GAIN_TRIM_ZERO     = 5'h08;
    localparam logic [1:0] SRC_PULSE_DENSITY  = 2'h2;
    localparam logic [1:0] SRC_CLONE_CH1      = 2'h3;
    localparam int DELAY_DEPTH                = 256;

endpackage

// ---- actr_delay_line.sv ----
// Modulator-clock delay line of 0 to 255 ticks for one pulse-density stream
`timescale 1ns/1ps

module actr_delay_line (
    input  wire logic       core_clk_in,
    input  wire logic       reset_n_in,
    input  wire logic       mod_tick_in,
    input  wire logic       stream_in,
    input  wire logic [7:0] delay_code_in,
    output logic            stream_out
);

    // ****************************************************************
    // Storage and pointer
    // ****************************************************************
    logic [actr_pkg::DELAY_DEPTH-1:0] history;
    logic [7:0]                       write_ptr;
    logic [7:0]                       read_ptr;
    logic                             next_stream;

    // Read slot lies delay_code ticks behind the slot about to be written
    assign read_ptr    = write_ptr - delay_code_in;
    assign next_stream = (delay_code_in == 8'h00) ? stream_in : history[read_ptr];

    // History is not reset; only entries already written are ever reached after a full lap
    always_ff @(posedge core_clk_in) begin
        if (mod_tick_in) begin
            history[write_ptr] <= stream_in;
        end
    end

    // Pointer and output advance only on a modulator tick
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            write_ptr  <= 8'h00;
            stream_out <= 1'b0;
        end else if (mod_tick_in) begin
            write_ptr  <= write_ptr + 8'h01;
            stream_out <= next_stream;
        end
    end

    chk_zero_delay_bypass : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        (mod_tick_in && delay_code_in == 8'h00) |=> (stream_out == $past(stream_in)))
        else $error("Zero phase code did not pass the stream straight through");

    chk_stream_hold : assert property (
        @(posedge core_clk_in) disable iff (!reset_n_in)
        !mod_tick_in |=> $stable(stream_out))
        else $error("Delayed stream changed without a modulator tick");

endmodule

// ---- tb_top.sv ----
// Self-checking testbench for the channel 5 and 6 trim register block
`timescale 1ns/1ps

module tb_top;
    logic       core_clk_in   = 1'b0;
    logic       reset_n_in    = 1'b0;
    logic [7:0] reg_addr_in   = 8'h00;
    logic       reg_write_in  = 1'b0;
    logic [7:0] reg_wdata_in  = 8'h00;
    logic       mod_tick_in   = 1'b0;
    logic       ch5_stream_in = 1'b0;
    logic [7:0] rdata, vol_code, phase_code;
    logic       stream_out, mute, use_pd, clone;
    logic [8:0] half_db;
    logic [3:0] trim_code;
    logic [4:0] trim_tenth, exp5;
    logic [1:0] src_sel;
    logic [7:0] dval;
    logic       hist [0:511];
    logic [7:0] vcodes [7] = '{8'h00, 8'h01, 8'h02, 8'hC8, 8'hC9, 8'hFE, 8'hFF};
    logic [8:0] vhalf  [7] = '{9'h137, 9'h138, 9'h139, 9'h1FF, 9'h000, 9'h035, 9'h036};
    logic [7:0] tcodes [4] = '{8'h00, 8'hF0, 8'h90, 8'h80};
    logic [7:0] pcodes [3] = '{8'h00, 8'h03, 8'hFF};
    int         error_cnt = 0;
    int         n_tests   = 0;

    // ****************************************************************
    // Clock, design instance and shared tasks
    // ****************************************************************
    always #10 core_clk_in = ~core_clk_in;

    actr_trim_regs u_dut (
        .core_clk_in(core_clk_in), .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in),
        .reg_write_in(reg_write_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata),
        .mod_tick_in(mod_tick_in), .ch5_stream_in(ch5_stream_in), .ch5_stream_out(stream_out),
        .ch5_volume_code_out(vol_code), .ch5_mute_out(mute), .ch5_volume_half_db_out(half_db),
        .ch5_gain_trim_code_out(trim_code), .ch5_gain_trim_tenth_db_out(trim_tenth),
        .ch5_phase_delay_code_out(phase_code), .ch6_input_source_sel_out(src_sel),
        .ch6_use_pulse_density_out(use_pd), .ch6_clone_ch1_out(clone)
    );

    // Compare and count; values are zero-extended to nine bits
    task automatic chk(input logic [8:0] got, input logic [8:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Strobe is held for exactly one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_write_in <= 1'b1;
        @(posedge core_clk_in);
        reg_write_in <= 1'b0;
    endtask

    // Read data answers on the same edge that samples the address
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk_in);
        reg_addr_in <= a;
        @(posedge core_clk_in);
        #1;
        chk({1'b0, rdata}, {1'b0, exp});
    endtask

    // Reset state of every register and derived output
    task automatic chk_resets;
        rd(actr_pkg::ADDR_CH5_VOLUME, 8'hC9);
        rd(actr_pkg::ADDR_CH5_GAIN_TRIM, 8'h80);
        rd(actr_pkg::ADDR_CH5_PHASE_TRIM, 8'h00);
        rd(actr_pkg::ADDR_CH6_INPUT_CONFIG, 8'h10);
        chk({1'b0, vol_code}, 9'h0C9);
        chk({8'h00, mute}, 9'h000);
        chk(half_db, 9'h000);
        chk({5'h00, trim_code}, 9'h008);
        chk({4'h0, trim_tenth}, 9'h000);
        chk({1'b0, phase_code}, 9'h000);
        chk({5'h00, use_pd, clone, src_sel}, 9'h000);
        chk({8'h00, stream_out}, 9'h000);
    endtask

    task automatic report_and_stop;
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog: the whole sequence needs about 2400 cycles
    initial begin
        repeat (20000) @(posedge core_clk_in);
        error_cnt++;
        report_and_stop();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (12) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        chk_resets();
        // Volume end points and the unity point, with derived gain
        foreach (vcodes[i]) begin
            wr(actr_pkg::ADDR_CH5_VOLUME, vcodes[i]);
            rd(actr_pkg::ADDR_CH5_VOLUME, vcodes[i]);
            chk({8'h00, mute}, {8'h00, vcodes[i] == 8'h00});
            chk(half_db, vhalf[i]);
            chk({1'b0, vol_code}, {1'b0, vcodes[i]});
        end
        // Trim codes across the range; low nibble is written zero and reads zero
        foreach (tcodes[i]) begin
            dval = tcodes[i];
            exp5 = {1'b0, dval[7:4]} - 5'h08;
            wr(actr_pkg::ADDR_CH5_GAIN_TRIM, dval);
            rd(actr_pkg::ADDR_CH5_GAIN_TRIM, {dval[7:4], 4'h0});
            chk({5'h00, trim_code}, {5'h00, dval[7:4]});
            chk({4'h0, trim_tenth}, {4'h0, exp5});
        end
        // Every source code, reserved bits kept at their reset values
        for (int s = 0; s < 4; s++) begin
            dval = {1'b0, 2'(s), 5'h10};
            wr(actr_pkg::ADDR_CH6_INPUT_CONFIG, dval);
            rd(actr_pkg::ADDR_CH6_INPUT_CONFIG, dval);
            chk({7'h00, src_sel}, 9'(s));
            chk({7'h00, use_pd, clone}, {7'h00, s == 2, s == 3});
        end
        // Unmapped address: ignored and reads zero, volume register untouched
        wr(8'h56, 8'hA5);
        rd(8'h56, actr_pkg::READ_UNMAPPED);
        rd(actr_pkg::ADDR_CH5_VOLUME, 8'hFF);
        // Phase delay: zero, small and largest code, uneven tick spacing
        foreach (pcodes[j]) begin
            wr(actr_pkg::ADDR_CH5_PHASE_TRIM, pcodes[j]);
            rd(actr_pkg::ADDR_CH5_PHASE_TRIM, pcodes[j]);
            chk({1'b0, phase_code}, {1'b0, pcodes[j]});
            for (int k = 0; k < 300; k++) begin
                @(posedge core_clk_in);
                hist[k] = k[0] ^ k[2] ^ k[5] ^ k[7];
                mod_tick_in   <= 1'b1;
                ch5_stream_in <= hist[k];
                @(posedge core_clk_in);
                mod_tick_in <= 1'b0;
                #1;
                // History is primed only after code-many ticks
                if (k >= int'(pcodes[j])) begin
                    chk({8'h00, stream_out}, {8'h00, hist[k - int'(pcodes[j])]});
                end
                if (k[1]) begin
                    @(posedge core_clk_in);
                end
            end
        end
        // Second reset in mid-run restores every default
        @(posedge core_clk_in);
        reset_n_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        reset_n_in <= 1'b1;
        chk_resets();
        report_and_stop();
    end
endmodule
